// ### core/vrs_consts.svh
`ifndef VRS_CONSTS_SVH
`define VRS_CONSTS_SVH
// ****************************************
// command bytes
// ****************************************
`define VRS_CMD_PU         8'h01
`define VRS_CMD_STOP       8'h02
`define VRS_CMD_RESET      8'h03
`define VRS_CMD_IRQ_CLR    8'h04
`define VRS_CMD_RD_STATUS  8'h05
`define VRS_CMD_RD_START   8'h06
`define VRS_CMD_SLEEP      8'h07
`define VRS_CMD_RD_FREE    8'h08
`define VRS_CMD_IDENT      8'h09
`define VRS_CMD_PLAY       8'h40
`define VRS_CMD_REC        8'h41
`define VRS_CMD_ERASE      8'h42
`define VRS_CMD_G_ERASE    8'h43
`define VRS_CMD_ANALOG_ROUTE_FETCH_CMD     8'h44
`define VRS_CMD_WR_APC1    8'h45
`define VRS_CMD_ADVANCE    8'h48
`define VRS_CMD_WR_APC2    8'h65
`define VRS_CMD_ARM_PLAY   8'h80
`define VRS_CMD_ARM_REC    8'h81
`define VRS_CMD_ARM_ERASE  8'h82
// ****************************************
// field positions and reset values
// ****************************************
`define VRS_SR1_RDY_BIT    0
`define VRS_SR1_ERASE_BIT  1
`define VRS_SR1_PLAY_BIT   2
`define VRS_SR1_REC_BIT    3
`define VRS_APC_RESET      12'h000
`define VRS_PTR_RESET      11'h000
`define VRS_APC_BYTES      3'h3
`define VRS_FRAME_BITS     6'h28
`endif

// ### core/vrs_pkg.sv
package vrs_pkg;
   // ****************************************
   // operation states, gray along idle-rec-play-erase-armed
   // ****************************************
   typedef enum logic [2:0] {
      OP_IDLE  = 3'h0,
      OP_REC   = 3'h1,
      OP_PLAY  = 3'h3,
      OP_ERASE = 3'h2,
      OP_ARMED = 3'h6
   } vrs_op_e;

   typedef struct packed {
      logic start_rec;
      logic start_play;
      logic start_erase;
      logic start_g_erase;
      logic arm_rec;
      logic arm_play;
      logic arm_erase;
      logic stop;
      logic dev_reset;
      logic sleep;
      logic power_up;
      logic advance;
   } vrs_pulse_s;

   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [2:0]  mosi_s;
      logic [2:0]  ssn_s;
      logic        sclk_f;
      logic        mosi_f;
      logic        ssn_f;
      logic [5:0]  bit_cnt;
      logic [7:0]  rx_sh;
      logic [7:0]  cmd;
      logic [7:0]  d1;
      logic [7:0]  d2;
      logic [2:0]  nbytes;
      logic [31:0] tx;
      logic        miso;
      vrs_op_e     op;
      logic        stoppable;
      logic        done_f;
      logic        eom_f;
      logic        cmd_err;
      logic        pu;
      logic [11:0] analog_route_reg;
      logic [10:0] start_ptr;
      logic [10:0] free_ptr;
      vrs_pulse_s  pulse;
   } vrs_state_s;
endpackage

// ### core/vrs_status_regs.sv
`include "vrs_consts.svh"

module vrs_status_regs
   import vrs_pkg::*;
#(
   parameter logic [4:0] PART_CODE = 5'h06  // arbitrary neutral value
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        spi_sclk,
   input  wire logic        spi_mosi,
   input  wire logic        spi_ss_n,
   output logic             spi_miso,
   input  wire logic        standalone_mode,
   input  wire logic [3:0]  effect_slots,
   input  wire logic [10:0] current_row,
   input  wire logic [10:0] next_msg_row,
   input  wire logic [2:0]  vol_pin_setting,
   input  wire logic        array_full,
   input  wire logic        op_done,
   input  wire logic        eom_detect,
   output vrs_pulse_s       cmd_pulse,
   output logic [11:0]      analog_route,
   output logic             powered_up
);
   vrs_state_s cur_reg;
   vrs_state_s nxt_next;

   // ****************************************
   // command acceptance
   // ****************************************
   function automatic logic is_priority(input logic [7:0] c);
      is_priority = (c == `VRS_CMD_RESET) || (c == `VRS_CMD_IRQ_CLR) ||
                    (c == `VRS_CMD_RD_STATUS) || (c == `VRS_CMD_SLEEP);
   endfunction

   logic [15:0] sr0;
   logic [7:0]  sr1;
   logic        busy;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        ss_start;
   logic        ss_end;
   logic [7:0]  rx_new;

   assign busy = (cur_reg.op != OP_IDLE);
   // ready only with no running or armed operation
   assign sr1  = {effect_slots[0], effect_slots[1], effect_slots[2],
                  effect_slots[3],
                  cur_reg.op == OP_REC, cur_reg.op == OP_PLAY,
                  cur_reg.op == OP_ERASE,
                  ~busy};
   assign sr0  = {current_row[10:3], current_row[2:0], cur_reg.done_f,
                  cur_reg.eom_f, cur_reg.pu, array_full, cur_reg.cmd_err};

   assign spi_miso     = cur_reg.miso;
   assign cmd_pulse    = cur_reg.pulse;
   assign analog_route = cur_reg.analog_route_reg;
   assign powered_up   = cur_reg.pu;

   always_comb begin
      nxt_next = cur_reg;
      nxt_next.pulse = '0;
      // ****************************************
      // pin synchronisers, three stages, agree filter
      // ****************************************
      nxt_next.sclk_s = {cur_reg.sclk_s[1:0], spi_sclk};
      nxt_next.mosi_s = {cur_reg.mosi_s[1:0], spi_mosi};
      nxt_next.ssn_s  = {cur_reg.ssn_s[1:0], spi_ss_n};
      if (cur_reg.sclk_s[1] == cur_reg.sclk_s[2]) begin
         nxt_next.sclk_f = cur_reg.sclk_s[2];
      end
      if (cur_reg.mosi_s[1] == cur_reg.mosi_s[2]) begin
         nxt_next.mosi_f = cur_reg.mosi_s[2];
      end
      if (cur_reg.ssn_s[1] == cur_reg.ssn_s[2]) begin
         nxt_next.ssn_f = cur_reg.ssn_s[2];
      end
      sclk_rise = nxt_next.sclk_f & ~cur_reg.sclk_f & ~cur_reg.ssn_f;
      sclk_fall = ~nxt_next.sclk_f & cur_reg.sclk_f & ~cur_reg.ssn_f;
      ss_start  = ~nxt_next.ssn_f & cur_reg.ssn_f;
      ss_end    = nxt_next.ssn_f & ~cur_reg.ssn_f;
      rx_new    = {cur_reg.mosi_f, cur_reg.rx_sh[7:1]};

      // ****************************************
      // serial shifting, lsb first
      // ****************************************
      if (ss_start) begin
         nxt_next.bit_cnt     = '0;
         nxt_next.nbytes      = '0;
         nxt_next.tx          = {16'h0000, sr0};
         nxt_next.miso        = sr0[0];
      end else if (sclk_rise && cur_reg.bit_cnt != `VRS_FRAME_BITS) begin
         nxt_next.rx_sh   = rx_new;
         nxt_next.bit_cnt = cur_reg.bit_cnt + 6'h01;
         if (cur_reg.bit_cnt[2:0] == 3'h7) begin
            nxt_next.nbytes = cur_reg.nbytes + 3'h1;
            if (cur_reg.nbytes == 3'h0) begin
               nxt_next.cmd = rx_new;
               // reply bytes chosen as soon as the opcode is known
               if (rx_new == `VRS_CMD_RD_STATUS) begin
                  nxt_next.tx[31:16] = {8'h00, sr1};
               end else if (rx_new == `VRS_CMD_RD_START) begin
                  nxt_next.tx[31:16] = {5'h00, cur_reg.start_ptr};
               end else if (rx_new == `VRS_CMD_RD_FREE) begin
                  nxt_next.tx[31:16] = {5'h00, cur_reg.free_ptr};
               end else if (rx_new == `VRS_CMD_ANALOG_ROUTE_FETCH_CMD) begin
                  nxt_next.tx[31:16] = {4'h0, cur_reg.analog_route_reg};
               end else if (rx_new == `VRS_CMD_IDENT) begin
                  nxt_next.tx[31:16] = {8'h00, PART_CODE, 3'h0};
               end else begin
                  nxt_next.tx[31:16] = 16'h0000;
               end
            end else if (cur_reg.nbytes == 3'h1) begin
               nxt_next.d1 = rx_new;
            end else if (cur_reg.nbytes == 3'h2) begin
               nxt_next.d2 = rx_new;
            end
         end
      end else if (sclk_fall) begin
         // past the fourth byte the line idles low
         nxt_next.miso = (cur_reg.bit_cnt < 6'h20) ?
                         cur_reg.tx[cur_reg.bit_cnt[4:0]] : 1'b0;
      end

      // ****************************************
      // array engine events
      // ****************************************
      if (op_done && busy) begin
         if (cur_reg.op == OP_REC) begin
            nxt_next.free_ptr = current_row;
         end
         nxt_next.op = OP_IDLE;
      end

      // ****************************************
      // execution at end of frame
      // ****************************************
      if (ss_end && cur_reg.nbytes != 3'h0) begin
         if (busy && !is_priority(cur_reg.cmd) &&
             !(cur_reg.cmd == `VRS_CMD_STOP && cur_reg.stoppable)) begin
            nxt_next.cmd_err = 1'b1;
         end else if ((cur_reg.cmd == `VRS_CMD_WR_APC1 ||
                       cur_reg.cmd == `VRS_CMD_WR_APC2) &&
                      cur_reg.nbytes < `VRS_APC_BYTES) begin
            nxt_next.cmd_err = 1'b1;
         end else begin
            nxt_next.cmd_err = 1'b0;
            case (cur_reg.cmd)
               `VRS_CMD_PU: begin
                  nxt_next.pu             = 1'b1;
                  nxt_next.pulse.power_up = 1'b1;
               end
               `VRS_CMD_STOP: begin
                  // stop reaches here only when idle or stoppable
                  nxt_next.pulse.stop = 1'b1;
                  if (cur_reg.op == OP_REC) begin
                     nxt_next.free_ptr = current_row;
                  end
                  nxt_next.op = OP_IDLE;
               end
               `VRS_CMD_RESET: begin
                  nxt_next.pulse.dev_reset = 1'b1;
                  nxt_next.op              = OP_IDLE;
                  nxt_next.start_ptr       = `VRS_PTR_RESET;
               end
               `VRS_CMD_IRQ_CLR: begin
                  nxt_next.done_f = 1'b0;
                  nxt_next.eom_f  = 1'b0;
               end
               `VRS_CMD_SLEEP: begin
                  nxt_next.pu          = 1'b0;
                  nxt_next.pulse.sleep = 1'b1;
               end
               `VRS_CMD_PLAY: begin
                  nxt_next.op               = OP_PLAY;
                  nxt_next.stoppable        = 1'b1;
                  nxt_next.pulse.start_play = 1'b1;
               end
               `VRS_CMD_REC: begin
                  nxt_next.op              = OP_REC;
                  nxt_next.stoppable       = 1'b1;
                  nxt_next.start_ptr       = cur_reg.free_ptr;
                  nxt_next.pulse.start_rec = 1'b1;
               end
               `VRS_CMD_ERASE: begin
                  nxt_next.op                = OP_ERASE;
                  nxt_next.stoppable         = 1'b0;
                  nxt_next.pulse.start_erase = 1'b1;
               end
               `VRS_CMD_G_ERASE: begin
                  nxt_next.op                  = OP_ERASE;
                  nxt_next.stoppable           = 1'b0;
                  nxt_next.pulse.start_g_erase = 1'b1;
               end
               `VRS_CMD_WR_APC1: begin
                  // volume comes from the pin, not the data
                  nxt_next.analog_route_reg = {cur_reg.d2[3:0], cur_reg.d1[7:3],
                                  vol_pin_setting};
               end
               `VRS_CMD_WR_APC2: begin
                  nxt_next.analog_route_reg = {cur_reg.d2[3:0], cur_reg.d1};
               end
               `VRS_CMD_ADVANCE: begin
                  nxt_next.start_ptr     = next_msg_row;
                  nxt_next.pulse.advance = 1'b1;
               end
               `VRS_CMD_ARM_PLAY: begin
                  nxt_next.op             = OP_ARMED;
                  nxt_next.stoppable      = 1'b1;
                  nxt_next.pulse.arm_play = 1'b1;
               end
               `VRS_CMD_ARM_REC: begin
                  nxt_next.op            = OP_ARMED;
                  nxt_next.stoppable     = 1'b1;
                  nxt_next.pulse.arm_rec = 1'b1;
               end
               `VRS_CMD_ARM_ERASE: begin
                  nxt_next.op              = OP_ARMED;
                  nxt_next.stoppable       = 1'b0;
                  nxt_next.pulse.arm_erase = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end

      // set wins over a clear in the same cycle
      if (op_done) begin
         nxt_next.done_f = 1'b1;
      end
      if (eom_detect) begin
         nxt_next.eom_f = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_reg        <= '0;
         cur_reg.sclk_s <= 3'h0;
         cur_reg.mosi_s <= 3'h0;
         cur_reg.ssn_s  <= 3'h7;
         cur_reg.ssn_f  <= 1'b1;
         cur_reg.op     <= OP_IDLE;
         cur_reg.analog_route_reg    <= `VRS_APC_RESET;
      end else begin
         cur_reg <= nxt_next;
      end
   end
endmodule

// ### testbench/vrs_checker.sv
module vrs_checker
   import vrs_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        spi_ss_n,
   input wire logic        op_done,
   input wire vrs_pulse_s  cmd_pulse,
   input wire logic [11:0] analog_route,
   input wire logic        powered_up
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // operation tracker rebuilt from pulses
   // ****
   logic busy_reg;
   logic busy_next;
   logic stop_ok_reg;
   logic stop_ok_next;
   logic start_any;
   assign start_any = cmd_pulse.start_rec | cmd_pulse.start_play
      | cmd_pulse.start_erase | cmd_pulse.start_g_erase | cmd_pulse.arm_rec
      | cmd_pulse.arm_play | cmd_pulse.arm_erase;
   always_comb begin
      busy_next = busy_reg;
      stop_ok_next = stop_ok_reg;
      if (start_any) begin
         busy_next = 1'b1;
         stop_ok_next = cmd_pulse.start_rec | cmd_pulse.start_play
            | cmd_pulse.arm_rec | cmd_pulse.arm_play;
      end else if (op_done | cmd_pulse.stop | cmd_pulse.dev_reset) begin
         busy_next = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         stop_ok_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
         stop_ok_reg <= stop_ok_next;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_ONE_PULSE: assert property ($onehot0(cmd_pulse))
      else $error("two command pulses at once");
   AST_PULSE_SHORT: assert property (cmd_pulse != '0 |=>
      cmd_pulse == '0) else $error("command pulse longer than one cycle");
   AST_PULSE_AFTER_FRAME: assert property (cmd_pulse != '0 |->
      spi_ss_n && $past(spi_ss_n, 2)) else $error("pulse inside a frame");
   AST_BUSY_REFUSE: assert property (busy_reg |-> !(start_any
      | cmd_pulse.power_up | cmd_pulse.advance)) else $error("busy took cmd");
   AST_STOP_ONLY_STOPPABLE: assert property (
      busy_reg && !stop_ok_reg |-> !cmd_pulse.stop)
      else $error("stop taken during erase");
   AST_APC_AT_FRAME_END: assert property ($changed(analog_route) |->
      spi_ss_n && cmd_pulse == '0) else $error("route changed badly");
   AST_PU_RISE: assert property ($rose(powered_up) |->
      cmd_pulse.power_up) else $error("power flag rose without power up");
   AST_PU_FALL: assert property ($fell(powered_up) |->
      cmd_pulse.sleep || cmd_pulse.dev_reset) else $error("power flag fell");
endmodule

bind vrs_status_regs vrs_checker chk_u (.clk(clk), .rst_n(rst_n),
   .spi_ss_n(spi_ss_n), .op_done(op_done), .cmd_pulse(cmd_pulse),
   .analog_route(analog_route), .powered_up(powered_up));

// ### testbench/vrs_host.sv
module vrs_host (
   input  wire logic clk,
   input  wire logic spi_miso,
   output logic      spi_sclk,
   output logic      spi_mosi,
   output logic      spi_ss_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // spi master, mode 0, lsb first, 160 ns bit period
   // ****
   initial begin
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
      spi_ss_n = 1'b1;
   end
   task automatic half();
      repeat (8) @(negedge clk);
   endtask
   task automatic frame(input logic [31:0] tx, input int nbits,
                        output logic [31:0] rx);
      rx = '0;
      @(negedge clk);
      spi_ss_n = 1'b0;
      spi_mosi = tx[0];
      half();
      for (int i = 0; i < nbits; i++) begin
         rx[i] = spi_miso;
         spi_sclk = 1'b1;
         half();
         spi_sclk = 1'b0;
         spi_mosi = (i < 31) ? tx[i+1] : ~spi_mosi;
         half();
      end
      spi_ss_n = 1'b1;
      // released line must not keep the last bit
      spi_mosi = ~spi_mosi;
      repeat (10) @(negedge clk);
   endtask
endmodule

// ### testbench/tb_top.sv
`include "vrs_consts.svh"
module tb_top
   import vrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // harness
   // ****
   localparam logic [4:0] PART = 5'h0b;  // arbitrary value
   logic clk, rst_n, sclk, mosi, ss_n, miso, standalone_mode;
   logic op_done, eom_detect, array_full, powered_up;
   logic done_m, eom_m, pu_m, err_m, clr_p;
   logic [3:0] effect_slots;
   logic [10:0] current_row, next_msg_row;
   logic [2:0] vol_pin_setting;
   logic [11:0] analog_route;
   logic [31:0] rx;
   vrs_pulse_s cmd_pulse, seen_p;
   int err_total, total_checks;
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // one driver only: the bench clears through a request flag
   always @(posedge clk) seen_p <= clr_p ? 12'h000 : (seen_p | cmd_pulse);
   vrs_status_regs #(.PART_CODE(PART)) dut_u (.clk(clk), .rst_n(rst_n),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_ss_n(ss_n), .spi_miso(miso),
      .standalone_mode(standalone_mode), .effect_slots(effect_slots),
      .current_row(current_row), .next_msg_row(next_msg_row),
      .vol_pin_setting(vol_pin_setting), .array_full(array_full),
      .op_done(op_done), .eom_detect(eom_detect), .cmd_pulse(cmd_pulse),
      .analog_route(analog_route), .powered_up(powered_up));
   vrs_host host_u (.clk(clk), .spi_miso(miso), .spi_sclk(sclk),
      .spi_mosi(mosi), .spi_ss_n(ss_n));
   task automatic results();
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic [7:0] c, input logic [15:0] d,
                      input int nb, input logic [11:0] p, input logic ok);
      clr_p = 1'b1;
      @(negedge clk);
      clr_p = 1'b0;
      host_u.frame({8'h00, d, c}, nb * 8, rx);
      chk({20'h0_0000, seen_p}, {20'h0_0000, p});
      err_m = ~ok;
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      host_u.frame({24'h00_0000, c}, 32, rx);
      chk({16'h0000, rx[15:0]}, {16'h0000, current_row, done_m, eom_m,
         pu_m, array_full, err_m});
      chk({16'h0000, rx[31:16]}, {16'h0000, e});
      err_m = 1'b0;
   endtask
   task automatic evt(input logic d, input logic e);
      @(negedge clk);
      op_done = d;
      eom_detect = e;
      @(negedge clk);
      op_done = 1'b0;
      eom_detect = 1'b0;
      done_m |= d;
      eom_m |= e;
      repeat (2) @(negedge clk);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      results();
   end
   initial begin
      {rst_n, standalone_mode, op_done, eom_detect, array_full} = 5'h01;
      {done_m, eom_m, pu_m, err_m, err_total, total_checks} = '0;
      effect_slots = 4'h9;
      current_row = 11'h5a3;
      next_msg_row = 11'h3c1;
      vol_pin_setting = 3'h5;
      clr_p = 1'b1;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk({20'h0_0000, analog_route}, 32'h0000_0000);
      rd(`VRS_CMD_RD_STATUS, 16'h0091);
      effect_slots = 4'h6;
      array_full = 1'b0;
      standalone_mode = 1'b1;
      rd(`VRS_CMD_RD_STATUS, 16'h0061);
      standalone_mode = 1'b0;
      rd(`VRS_CMD_IDENT, {8'h00, PART, 3'b000});
      run(`VRS_CMD_WR_APC2, 16'hfa5c, 3, 12'h000, 1'b1);
      rd(`VRS_CMD_ANALOG_ROUTE_FETCH_CMD, 16'h0a5c);
      run(`VRS_CMD_WR_APC1, 16'h0398, 3, 12'h000, 1'b1);
      chk({20'h0_0000, analog_route}, 32'h0000_039d);
      run(`VRS_CMD_WR_APC2, 16'h00ff, 2, 12'h000, 1'b0);
      rd(`VRS_CMD_ANALOG_ROUTE_FETCH_CMD, 16'h039d);
      run(`VRS_CMD_PU, 16'h0000, 2, 12'h002, 1'b1);
      pu_m = 1'b1;
      chk({31'h0000_0000, powered_up}, 32'h0000_0001);
      run(`VRS_CMD_PLAY, 16'h0000, 2, 12'h400, 1'b1);
      rd(`VRS_CMD_RD_STATUS, 16'h0064);
      run(`VRS_CMD_REC, 16'h0000, 2, 12'h000, 1'b0);
      run(`VRS_CMD_PU, 16'h0000, 2, 12'h000, 1'b0);
      run(`VRS_CMD_IRQ_CLR, 16'h0000, 2, 12'h000, 1'b1);
      run(`VRS_CMD_SLEEP, 16'h0000, 2, 12'h004, 1'b1);
      pu_m = 1'b0;
      chk({31'h0000_0000, powered_up}, 32'h0000_0000);
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h010, 1'b1);
      rd(`VRS_CMD_RD_STATUS, 16'h0061);
      current_row = 11'h123;
      run(`VRS_CMD_REC, 16'h0000, 2, 12'h800, 1'b1);
      rd(`VRS_CMD_RD_STATUS, 16'h0068);
      evt(1'b1, 1'b0);
      rd(`VRS_CMD_RD_FREE, 16'h0123);
      rd(`VRS_CMD_RD_START, 16'h0000);
      run(`VRS_CMD_REC, 16'h0000, 2, 12'h800, 1'b1);
      current_row = 11'h2f0;
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h010, 1'b1);
      rd(`VRS_CMD_RD_START, 16'h0123);
      rd(`VRS_CMD_RD_FREE, 16'h02f0);
      evt(1'b0, 1'b1);
      run(`VRS_CMD_IRQ_CLR, 16'h0000, 2, 12'h000, 1'b1);
      {done_m, eom_m} = 2'h0;
      rd(`VRS_CMD_RD_STATUS, 16'h0061);
      run(`VRS_CMD_ADVANCE, 16'h0000, 2, 12'h001, 1'b1);
      rd(`VRS_CMD_RD_START, 16'h03c1);
      run(`VRS_CMD_RESET, 16'h0000, 2, 12'h008, 1'b1);
      rd(`VRS_CMD_RD_START, 16'h0000);
      run(`VRS_CMD_ERASE, 16'h0000, 2, 12'h200, 1'b1);
      rd(`VRS_CMD_RD_STATUS, 16'h0062);
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h000, 1'b0);
      evt(1'b1, 1'b0);
      run(`VRS_CMD_G_ERASE, 16'h0000, 2, 12'h100, 1'b1);
      evt(1'b1, 1'b0);
      run(`VRS_CMD_IRQ_CLR, 16'h0000, 2, 12'h000, 1'b1);
      done_m = 1'b0;
      run(`VRS_CMD_ARM_REC, 16'h0000, 3, 12'h080, 1'b1);
      rd(`VRS_CMD_RD_STATUS, 16'h0060);
      run(`VRS_CMD_ARM_PLAY, 16'h0000, 3, 12'h000, 1'b0);
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h010, 1'b1);
      run(`VRS_CMD_ARM_PLAY, 16'h0000, 3, 12'h040, 1'b1);
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h010, 1'b1);
      run(`VRS_CMD_ARM_ERASE, 16'h0000, 3, 12'h020, 1'b1);
      run(`VRS_CMD_STOP, 16'h0000, 2, 12'h000, 1'b0);
      run(`VRS_CMD_RESET, 16'h0000, 2, 12'h008, 1'b1);
      // mid-run reset must bring the route register back
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk({20'h0_0000, analog_route}, 32'h0000_0000);
      chk({31'h0000_0000, powered_up}, 32'h0000_0000);
      rd(`VRS_CMD_RD_STATUS, 16'h0061);
      results();
   end
endmodule
